// file: smbus_host_cfg.svh
`ifndef SMBUS_HOST_CFG_SVH
`define SMBUS_HOST_CFG_SVH

// strap codes from the strap resistor decoder
`define STRAP_GND        3'h0
`define STRAP_56K        3'h1
`define STRAP_68K        3'h2
`define STRAP_82K        3'h3
`define STRAP_100K       3'h4
`define STRAP_120K       3'h5
`define STRAP_150K       3'h6
`define STRAP_VDD        3'h7

// two-wire slave addresses per strap
`define SLAVE_ADDR_82K   7'h2C
`define SLAVE_ADDR_100K  7'h2B
`define SLAVE_ADDR_120K  7'h2A
`define SLAVE_ADDR_150K  7'h29
`define SLAVE_ADDR_VDD   7'h28

// clock rates
`define CLK_FREQ_KHZ     125000
`define LINK_FREQ_KHZ    6250

// power-up blackout
`define BLACKOUT_MS      15
`define BLACKOUT_CYC     (`BLACKOUT_MS * `CLK_FREQ_KHZ)

// clock-low timeout and idle reset, counted on the link clock
`define BUS_TMO_MS       30
`define BUS_TMO_CYC      (`BUS_TMO_MS * `LINK_FREQ_KHZ)
`define BUS_IDLE_US      200
`define BUS_IDLE_CYC     ((`BUS_IDLE_US * `LINK_FREQ_KHZ + 999) / 1000)

// strap capture point after reset release
`define STRAP_TAKE_CYC   24'h000004

// reset values
`define PTR_RESET        8'h00
`define BYTE_RESET       8'h00

`endif

// file: smbus_host_pkg.sv
`default_nettype none

package smbus_host_pkg;

	typedef enum logic [2:0] {
		ph_idle, ph_rx, ph_ack, ph_tx, ph_mack, ph_wait
	} phase_e;

	typedef struct packed {
		logic two_wire;
		logic spi_four_wire;
		logic spi_three_wire;
		logic spi_selected;
	} proto_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_port_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} xfer_s;

	typedef struct packed {
		logic [2:0]  strap_m;
		logic [2:0]  strap_s;
		logic [2:0]  strap;
		logic        taken;
		logic [23:0] boot_cnt;
		logic        ready;
		logic        cs_m;
		logic        cs_s;
		logic        wr_m;
		logic        wr_s;
		logic        wr_seen;
		logic        rd_m;
		logic        rd_s;
		logic        rd_seen;
		logic        rd_busy;
		logic        rd_tog;
		logic [7:0]  rd_data;
		reg_port_s   port;
		proto_s      proto;
	} core_s;

	typedef struct packed {
		logic        rst_m;
		logic        rst_s;
		logic        scl_m;
		logic        scl_s;
		logic        scl_d;
		logic        scl_f;
		logic        scl_p;
		logic        sda_m;
		logic        sda_s;
		logic        sda_d;
		logic        sda_f;
		logic        sda_p;
		logic [2:0]  strap_m;
		logic [2:0]  strap_s;
		logic        ready_m;
		logic        ready_s;
		logic        tmo_m;
		logic        tmo_s;
		logic        slp_m;
		logic        slp_s;
		logic        rdb_m;
		logic        rdb_s;
		logic        rdb_seen;
		phase_e      phase;
		logic [3:0]  bit_cnt;
		logic [1:0]  byte_n;
		logic        rw;
		logic [7:0]  shreg;
		logic        ack_seen;
		logic [7:0]  ptr;
		logic [7:0]  pend_ptr;
		logic        pend;
		logic [7:0]  txd;
		logic        sda_oe;
		logic        wr_tog;
		xfer_s       wr;
		logic        rd_tog;
		logic [7:0]  rd_addr;
		logic [23:0] tmo_cnt;
		logic [23:0] idle_cnt;
	} link_s;

endpackage : smbus_host_pkg

`default_nettype wire

// file: smbus_register_host_interface.sv
// Behaviour
// - two-wire strap picks one of five 7-bit slave addresses
// - ground strap selects four-wire SPI, 56k three-wire SPI, 68k nothing
// - two-wire mode serves send, receive, read, write byte and block transfers
// - chip-select input is ignored in two-wire mode
// - host traffic is ignored during the 15 ms power-up blackout
// - the bus clock is never held low by this device
// - start is data falling while clock is high
// - first byte is slave address plus direction bit, 1 means read
// - bytes are eight bits, most significant bit first
// - every received byte but a non-matching address is acknowledged on the ninth clock
// - after host not-acknowledge, data line is released and sending stops
// - stop is data rising while clock high; slave returns to idle
// - with timeout enabled, clock low for 30 ms resets the slave
// - with timeout enabled, both lines high over 200 us resets slave
// - block transfers carry no count byte and run until stop or NACK
// - write byte stores the data byte at the register address
// - read byte returns one register after repeated start and read address
// - address-only write loads the pointer and moves no data
// - in deep sleep the address-only write leaves the pointer alone
// - receive-only read returns the register at the unchanged pointer
// - pointer advances after each acknowledged block data byte, wrapping FFh to 00h

`include "smbus_host_cfg.svh"

`default_nettype none

module smbus_register_host_interface #(
	parameter int BOOT_CYCLES    = `BLACKOUT_CYC,
	parameter int TIMEOUT_CYCLES = `BUS_TMO_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic                      link_clk,
	input  wire logic                      host_bus_clock_pin_i,
	output logic                           host_bus_clock_pin_o,
	output logic                           host_bus_clock_pin_oe,
	input  wire logic                      host_bus_data_pin_i,
	output logic                           host_bus_data_pin_o,
	output logic                           host_bus_data_pin_oe,
	input  wire logic                      spi_cs_n,
	input  wire logic [2:0]                protocol_address_strap,
	input  wire logic                      timeout_enable,
	input  wire logic                      deep_sleep_flag,
	output smbus_host_pkg::reg_port_s      reg_port,
	input  wire logic [7:0]                reg_rdata,
	output smbus_host_pkg::proto_s         proto,
	output logic                           interface_ready
);
	import smbus_host_pkg::*;

	localparam logic [23:0] BOOT_LIMIT = 24'(BOOT_CYCLES);
	localparam logic [23:0] TMO_LIMIT  = 24'(TIMEOUT_CYCLES);
	localparam logic [23:0] IDLE_LIMIT = 24'(`BUS_IDLE_CYC);

	core_s c;
	core_s next_c;
	link_s l;
	link_s next_l;

	// strap decode: is the two-wire protocol selected
	function automatic logic strap_two_wire(input logic [2:0] s);
		return (s >= `STRAP_82K);
	endfunction : strap_two_wire

	// strap decode: slave address for two-wire straps
	function automatic logic [6:0] strap_addr(input logic [2:0] s);
		logic [6:0] a;
		a = `SLAVE_ADDR_VDD;
		unique case (s)
			`STRAP_82K:  a = `SLAVE_ADDR_82K;
			`STRAP_100K: a = `SLAVE_ADDR_100K;
			`STRAP_120K: a = `SLAVE_ADDR_120K;
			`STRAP_150K: a = `SLAVE_ADDR_150K;
			default:     a = `SLAVE_ADDR_VDD;
		endcase
		return a;
	endfunction : strap_addr

	// saturating counter step
	function automatic logic [23:0] count_up(input logic [23:0] v,
		input logic [23:0] lim);
		return (v >= lim) ? v : v + 24'h000001;
	endfunction : count_up

	// ---------------- system clock side ----------------

	// strap capture, blackout, register port, crossings from link
	always_comb begin
		next_c = c;
		next_c.strap_m = protocol_address_strap;
		next_c.strap_s = c.strap_m;
		next_c.cs_m    = spi_cs_n;
		next_c.cs_s    = c.cs_m;
		next_c.wr_m    = l.wr_tog;
		next_c.wr_s    = c.wr_m;
		next_c.rd_m    = l.rd_tog;
		next_c.rd_s    = c.rd_m;
		next_c.port.wr = 1'b0;
		next_c.port.rd = 1'b0;

		// blackout counter runs once after reset
		next_c.boot_cnt = count_up(c.boot_cnt, BOOT_LIMIT);
		if (c.boot_cnt >= BOOT_LIMIT) begin
			next_c.ready = 1'b1;
		end

		// strap latched once, after its synchroniser has settled
		if (!c.taken && c.boot_cnt == `STRAP_TAKE_CYC) begin
			next_c.strap = c.strap_s;
			next_c.taken = 1'b1;
		end

		// protocol outputs from the latched strap
		next_c.proto.two_wire       = c.taken && strap_two_wire(c.strap);
		next_c.proto.spi_four_wire  = c.taken && c.strap == `STRAP_GND;
		next_c.proto.spi_three_wire = c.taken && c.strap == `STRAP_56K;
		// chip select only counts in an SPI mode
		next_c.proto.spi_selected = c.taken && !c.cs_s &&
			(c.strap == `STRAP_GND || c.strap == `STRAP_56K);

		// write request from the link: addr and data are stable here
		if (c.wr_s != c.wr_seen) begin
			next_c.wr_seen    = c.wr_s;
			next_c.port.wr    = 1'b1;
			next_c.port.addr  = l.wr.addr;
			next_c.port.wdata = l.wr.data;
		end else if (c.rd_s != c.rd_seen) begin
			// read request: strobe now, capture data next cycle
			next_c.rd_seen   = c.rd_s;
			next_c.port.rd   = 1'b1;
			next_c.port.addr = l.rd_addr;
			next_c.rd_busy   = 1'b1;
		end
		if (c.rd_busy) begin
			next_c.rd_data = reg_rdata;
			next_c.rd_tog  = ~c.rd_tog;
			next_c.rd_busy = 1'b0;
		end

		if (sys_rst) begin
			next_c.strap    = `STRAP_68K;
			next_c.taken    = 1'b0;
			next_c.boot_cnt = 24'h000000;
			next_c.ready    = 1'b0;
			next_c.wr_seen  = 1'b0;
			next_c.rd_seen  = 1'b0;
			next_c.rd_busy  = 1'b0;
			next_c.rd_tog   = 1'b0;
			next_c.rd_data  = `BYTE_RESET;
			next_c.port     = '0;
			next_c.proto    = '0;
		end
	end

	// system clock state register
	always_ff @(posedge clk) begin
		c <= next_c;
	end

	// ---------------- link clock side ----------------

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic bus_reset;
	logic enabled;
	logic addr_hit;
	logic [7:0] rx_byte;
	logic [7:0] wr_addr;

	// edges and conditions on the filtered lines
	always_comb begin
		scl_rise   = l.scl_f && !l.scl_p;
		scl_fall   = !l.scl_f && l.scl_p;
		// data falling with clock high both samples
		start_seen = l.scl_f && l.scl_p && l.sda_p && !l.sda_f;
		stop_seen  = l.scl_f && l.scl_p && !l.sda_p && l.sda_f;
		bus_reset  = l.tmo_s && (l.tmo_cnt >= TMO_LIMIT ||
			l.idle_cnt >= IDLE_LIMIT);
		enabled    = l.ready_s && strap_two_wire(l.strap_s);
		rx_byte    = l.shreg;
		addr_hit   = rx_byte[7:1] == strap_addr(l.strap_s);
		wr_addr    = l.pend ? l.pend_ptr : l.ptr;
	end

	// two-wire slave engine
	always_comb begin
		next_l = l;
		// reset synchroniser and line synchronisers
		next_l.rst_m   = sys_rst;
		next_l.rst_s   = l.rst_m;
		next_l.scl_m   = host_bus_clock_pin_i;
		next_l.scl_s   = l.scl_m;
		next_l.scl_d   = l.scl_s;
		next_l.sda_m   = host_bus_data_pin_i;
		next_l.sda_s   = l.sda_m;
		next_l.sda_d   = l.sda_s;
		next_l.strap_m = c.strap;
		next_l.strap_s = l.strap_m;
		next_l.ready_m = c.ready;
		next_l.ready_s = l.ready_m;
		next_l.tmo_m   = timeout_enable;
		next_l.tmo_s   = l.tmo_m;
		next_l.slp_m   = deep_sleep_flag;
		next_l.slp_s   = l.slp_m;
		next_l.rdb_m   = c.rd_tog;
		next_l.rdb_s   = l.rdb_m;

		// two matching samples needed before a line level is taken
		if (l.scl_s == l.scl_d) begin
			next_l.scl_f = l.scl_s;
		end
		if (l.sda_s == l.sda_d) begin
			next_l.sda_f = l.sda_s;
		end
		next_l.scl_p = l.scl_f;
		next_l.sda_p = l.sda_f;

		// read data returning from the register side
		if (l.rdb_s != l.rdb_seen) begin
			next_l.rdb_seen = l.rdb_s;
			next_l.txd      = c.rd_data;
		end

		// clock-low and idle watchdogs
		next_l.tmo_cnt = (l.tmo_s && !l.scl_f) ?
			count_up(l.tmo_cnt, TMO_LIMIT) : 24'h000000;
		next_l.idle_cnt = (l.tmo_s && l.scl_f && l.sda_f) ?
			count_up(l.idle_cnt, IDLE_LIMIT) : 24'h000000;

		unique case (l.phase)
			ph_idle, ph_wait: begin
			end
			ph_rx: begin
				// shift in on rising clock, msb first
				if (scl_rise) begin
					next_l.shreg   = {l.shreg[6:0], l.sda_f};
					next_l.bit_cnt = l.bit_cnt + 4'h1;
				end
				if (scl_fall && l.bit_cnt == 4'h8) begin
					next_l.phase  = ph_ack;
					next_l.sda_oe = 1'b1;
					if (l.byte_n == 2'h0) begin
						next_l.rw = rx_byte[0];
						if (!addr_hit) begin
							next_l.phase  = ph_wait;
							next_l.sda_oe = 1'b0;
						end else if (rx_byte[0]) begin
							// fetch the byte at the unchanged pointer
							next_l.rd_addr = l.ptr;
							next_l.rd_tog  = ~l.rd_tog;
						end
					end else if (l.byte_n == 2'h1) begin
						// held until data, repeated start or stop
						next_l.pend_ptr = rx_byte;
						next_l.pend     = 1'b1;
					end else begin
						// data byte: store and step the pointer
						next_l.wr.addr = wr_addr;
						next_l.wr.data = rx_byte;
						next_l.wr_tog  = ~l.wr_tog;
						next_l.ptr     = wr_addr + 8'h01;
						next_l.pend    = 1'b0;
					end
				end
			end
			ph_ack: begin
				// release at end of the ninth clock
				if (scl_fall) begin
					next_l.sda_oe  = 1'b0;
					next_l.bit_cnt = 4'h0;
					if (l.rw) begin
						next_l.phase  = ph_tx;
						next_l.shreg  = l.txd;
						next_l.sda_oe = !l.txd[7];
						// prefetch the next byte of a block read
						next_l.rd_addr = l.ptr + 8'h01;
						next_l.rd_tog  = ~l.rd_tog;
					end else begin
						next_l.phase = ph_rx;
						if (l.byte_n != 2'h2) begin
							next_l.byte_n = l.byte_n + 2'h1;
						end
					end
				end
			end
			ph_tx: begin
				// next bit on each falling clock, never holding clock
				if (scl_fall) begin
					if (l.bit_cnt == 4'h7) begin
						next_l.sda_oe  = 1'b0;
						next_l.phase   = ph_mack;
						next_l.bit_cnt = 4'h0;
					end else begin
						next_l.shreg   = {l.shreg[6:0], 1'b0};
						next_l.sda_oe  = !l.shreg[6];
						next_l.bit_cnt = l.bit_cnt + 4'h1;
					end
				end
			end
			ph_mack: begin
				// host acknowledge sampled on the ninth rising clock
				if (scl_rise) begin
					next_l.ack_seen = !l.sda_f;
				end
				if (scl_fall) begin
					if (l.ack_seen) begin
						next_l.ptr     = l.ptr + 8'h01;
						next_l.phase   = ph_tx;
						next_l.shreg   = l.txd;
						next_l.sda_oe  = !l.txd[7];
						next_l.rd_addr = l.ptr + 8'h02;
						next_l.rd_tog  = ~l.rd_tog;
					end else begin
						// not-acknowledged: stay off the bus until stop or start
						next_l.phase = ph_wait;
					end
				end
			end
			default: begin
				next_l.phase  = ph_idle;
				next_l.sda_oe = 1'b0;
			end
		endcase

		// start or repeated start begins address reception
		if (start_seen && enabled) begin
			next_l.phase   = ph_rx;
			next_l.bit_cnt = 4'h0;
			next_l.byte_n  = 2'h0;
			next_l.sda_oe  = 1'b0;
			if (l.pend) begin
				next_l.ptr  = l.pend_ptr;
				next_l.pend = 1'b0;
			end
		end

		// stop: address-only write loads the pointer unless asleep
		if (stop_seen) begin
			next_l.phase  = ph_idle;
			next_l.sda_oe = 1'b0;
			next_l.pend   = 1'b0;
			if (l.pend && !l.slp_s) begin
				next_l.ptr = l.pend_ptr;
			end
		end

		// watchdog or disabled protocol drops the slave to idle
		if (bus_reset || !enabled) begin
			next_l.phase  = ph_idle;
			next_l.sda_oe = 1'b0;
			next_l.pend   = 1'b0;
		end

		if (l.rst_s) begin
			next_l.phase    = ph_idle;
			next_l.bit_cnt  = 4'h0;
			next_l.byte_n   = 2'h0;
			next_l.rw       = 1'b0;
			next_l.shreg    = `BYTE_RESET;
			next_l.ack_seen = 1'b0;
			next_l.ptr      = `PTR_RESET;
			next_l.pend_ptr = `PTR_RESET;
			next_l.pend     = 1'b0;
			next_l.txd      = `BYTE_RESET;
			next_l.sda_oe   = 1'b0;
			next_l.wr_tog   = 1'b0;
			next_l.wr       = '0;
			next_l.rd_tog   = 1'b0;
			next_l.rd_addr  = `PTR_RESET;
			next_l.rdb_seen = 1'b0;
			next_l.tmo_cnt  = 24'h000000;
			next_l.idle_cnt = 24'h000000;
			next_l.scl_f    = 1'b1;
			next_l.scl_p    = 1'b1;
			next_l.sda_f    = 1'b1;
			next_l.sda_p    = 1'b1;
		end
	end

	// link clock state register
	always_ff @(posedge link_clk) begin
		l <= next_l;
	end

	// pin drive: data is open drain, clock is never driven
	always_comb begin
		host_bus_data_pin_o   = 1'b0;
		host_bus_data_pin_oe  = l.sda_oe;
		host_bus_clock_pin_o  = 1'b0;
		host_bus_clock_pin_oe = 1'b0;
		reg_port              = c.port;
		proto                 = c.proto;
		interface_ready       = c.ready;
	end

endmodule : smbus_register_host_interface

`default_nettype wire

// file: smbus_register_host_interface_props.sv
`include "smbus_host_cfg.svh"
`default_nettype none

module smbus_register_host_interface_chk
	import smbus_host_pkg::*;
#(
	parameter int BOOT_CYCLES = 50
) (
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire logic                 host_bus_clock_pin_oe,
	input wire logic                 host_bus_data_pin_oe,
	input wire logic                 host_bus_clock_pin_o,
	input wire logic                 host_bus_data_pin_o,
	input wire logic [2:0]           protocol_address_strap,
	input wire smbus_host_pkg::reg_port_s reg_port,
	input wire smbus_host_pkg::proto_s    proto,
	input wire logic                 interface_ready
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] since;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// cycles since reset release
	always_ff @(posedge clk) begin
		if (sys_rst)
			since <= '0;
		else if (since != '1)
			since <= since + 32'h1;
	end

	chk_clock_never_held: assert property (
		!host_bus_clock_pin_oe) else $error("clock line driven");
	chk_open_drain_low: assert property (
		!host_bus_clock_pin_o && !host_bus_data_pin_o)
		else $error("pin output level not low");
	chk_quiet_before_ready: assert property (
		!interface_ready |-> !host_bus_data_pin_oe)
		else $error("data driven before ready");
	chk_ready_after_boot: assert property (
		$rose(interface_ready) |->
		since inside {[BOOT_CYCLES - 1:BOOT_CYCLES + 3]})
		else $error("ready at wrong time");
	chk_ground_spi_four: assert property (
		interface_ready && protocol_address_strap == `STRAP_GND |->
		proto.spi_four_wire && !proto.two_wire)
		else $error("ground strap mode wrong");
	chk_strap_spi_three: assert property (
		interface_ready && protocol_address_strap == `STRAP_56K |->
		proto.spi_three_wire && !proto.two_wire)
		else $error("56k strap mode wrong");
	chk_reserved_no_mode: assert property (
		interface_ready && protocol_address_strap == `STRAP_68K |->
		!(proto.two_wire || proto.spi_four_wire || proto.spi_three_wire))
		else $error("reserved strap picked a mode");
	chk_two_wire_mode: assert property (
		interface_ready && protocol_address_strap >= `STRAP_82K |->
		proto.two_wire && !proto.spi_selected)
		else $error("two-wire mode wrong");
	chk_silent_off_bus: assert property (
		interface_ready && !proto.two_wire |-> !host_bus_data_pin_oe)
		else $error("acknowledge outside two-wire mode");
	chk_write_one_cycle: assert property (
		reg_port.wr |=> !reg_port.wr) else $error("write strobe too long");
	chk_read_one_cycle: assert property (
		reg_port.rd |=> !reg_port.rd) else $error("read strobe too long");

	cov_write: cover property (reg_port.wr);
	cov_read: cover property (reg_port.rd);
	cov_ack: cover property ($rose(host_bus_data_pin_oe));

endmodule : smbus_register_host_interface_chk

bind smbus_register_host_interface smbus_register_host_interface_chk #(
	.BOOT_CYCLES(BOOT_CYCLES)
) chk_inst (
	.clk, .sys_rst, .host_bus_clock_pin_oe, .host_bus_data_pin_oe,
	.host_bus_clock_pin_o, .host_bus_data_pin_o,
	.protocol_address_strap, .reg_port, .proto, .interface_ready
);

`default_nettype wire

// file: host_bus_master.sv
`default_nettype none

module host_bus_master #(
	parameter int T = 1300 // half bit, about 385 kHz
) (
	input  wire logic scl,
	input  wire logic sda,
	output var logic  scl_low,
	output var logic  sda_low
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// start or repeated start: data falls, clock high
	task automatic start();
		sda_low = 1'b0;
		#T scl_low = 1'b0;
		#T sda_low = 1'b1;
		#T scl_low = 1'b1;
	endtask : start

	// stop: data rises, clock high
	task automatic stop();
		sda_low = 1'b1;
		#T scl_low = 1'b0;
		#T sda_low = 1'b0;
		#T;
	endtask : stop

	// eight bits msb first, then acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_low = (i == 0) ? !ack_in : !d[i - 1];
			#T scl_low = 1'b0;
			#T;
			if (i == 0)
				ack = sda;
			else
				q[i - 1] = sda;
			scl_low = 1'b1;
		end
	endtask : xfer

	// stretch clock low, or release the clock and idle both lines high
	task automatic hold(input logic hi, input int dly);
		if (hi) begin
			#T scl_low = 1'b0;
		end
		#dly scl_low = 1'b1;
	endtask : hold

endmodule : host_bus_master

`default_nettype wire

// file: smbus_register_host_interface_tb.sv
`include "smbus_host_cfg.svh"
`default_nettype none
`define CHK(a, b) cmp(32'(a), 32'(b))

module smbus_register_host_interface_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import smbus_host_pkg::*;

	localparam logic [6:0] A = `SLAVE_ADDR_VDD;
	localparam logic [6:0] SA [8] = '{7'h00, 7'h00, 7'h00,
		`SLAVE_ADDR_82K, `SLAVE_ADDR_100K, `SLAVE_ADDR_120K,
		`SLAVE_ADDR_150K, `SLAVE_ADDR_VDD};

	logic       clk, link_clk, sys_rst, spi_cs_n;
	logic       timeout_enable, deep_sleep_flag, interface_ready;
	logic       scl_oe, sda_oe, scl_low, sda_low;
	logic [2:0] protocol_address_strap;
	logic [7:0] reg_rdata;
	logic [7:0] mem [256];
	reg_port_s  reg_port;
	proto_s     proto;
	int         n_errors, checked;
	wire logic  scl = !(scl_low | scl_oe); // pull-up
	wire logic  sda = !(sda_low | sda_oe);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end

	// register file behind the port
	always @(posedge clk) begin
		if (reg_port.wr)
			mem[reg_port.addr] <= reg_port.wdata;
	end

	// read data follows the address at once, ready the cycle after rd
	always_comb begin
		reg_rdata = mem[reg_port.addr];
	end

	smbus_register_host_interface #(
		.BOOT_CYCLES(50), .TIMEOUT_CYCLES(200)
	) smbus_register_host_interface_inst (
		.clk, .sys_rst, .link_clk, .spi_cs_n, .protocol_address_strap,
		.timeout_enable, .deep_sleep_flag, .reg_port, .reg_rdata, .proto,
		.interface_ready,
		.host_bus_clock_pin_i(scl), .host_bus_clock_pin_o(),
		.host_bus_clock_pin_oe(scl_oe), .host_bus_data_pin_i(sda),
		.host_bus_data_pin_o(), .host_bus_data_pin_oe(sda_oe)
	);

	host_bus_master host_bus_master_inst (
		.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low)
	);

	function automatic logic [7:0] pat(input int i);
		return 8'(i) ^ 8'hA5;
	endfunction : pat

	task automatic cmp(input logic [31:0] a, input logic [31:0] e);
		checked++;
		if (a !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, a, e);
		end
	endtask : cmp

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	// reset long enough for the link domain, then wait for ready
	task automatic do_reset(input int s);
		@(posedge clk);
		#1 sys_rst = 1'b1;
		protocol_address_strap = 3'(s);
		spi_cs_n = s[1];
		repeat (5) @(posedge link_clk);
		@(posedge clk);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 80 && interface_ready !== 1'b1; i++)
			@(posedge clk);
		`CHK(interface_ready, 1'b1);
		repeat (4) @(posedge link_clk);
	endtask : do_reset

	// start plus address byte
	task automatic go(input logic rd, input logic [6:0] a, input logic e);
		logic [7:0] q;
		logic       k;
		host_bus_master_inst.start();
		host_bus_master_inst.xfer({a, rd}, 1'b1, q, k);
		`CHK(k, e);
	endtask : go

	task automatic wb(input logic [7:0] d, input logic e);
		logic [7:0] q;
		logic       k;
		host_bus_master_inst.xfer(d, 1'b1, q, k);
		`CHK(k, e);
	endtask : wb

	task automatic rb(input logic [7:0] e, input logic last);
		logic [7:0] q;
		logic       k;
		host_bus_master_inst.xfer(8'hFF, last, q, k);
		`CHK(q, e);
	endtask : rb

	task automatic t_straps();
		for (int s = 0; s < 8; s++) begin
			do_reset(s);
			`CHK(proto.two_wire, s >= 3);
			`CHK(proto.spi_four_wire, s == 0);
			`CHK(proto.spi_three_wire, s == 1);
			`CHK(proto.spi_selected, s < 2);
			if (s >= 3) begin
				go(1'b0, SA[s], 1'b0);
				host_bus_master_inst.stop();
			end
		end
		go(1'b0, `SLAVE_ADDR_82K, 1'b1);
		host_bus_master_inst.stop();
		$display("strap test done");
	endtask : t_straps

	task automatic t_block_write();
		go(1'b0, A, 1'b0);
		wb(8'hFE, 1'b0);
		wb(8'h11, 1'b0);
		wb(8'h22, 1'b0);
		wb(8'h33, 1'b0);
		host_bus_master_inst.stop();
		`CHK(mem[8'hFE], 8'h11);
		`CHK(mem[8'hFF], 8'h22);
		`CHK(mem[8'h00], 8'h33);
		$display("block write test done");
	endtask : t_block_write

	task automatic t_reads();
		go(1'b0, A, 1'b0);
		wb(8'hFF, 1'b0);
		go(1'b1, A, 1'b0);
		rb(8'h22, 1'b1);
		// next byte would start low, so the slave must stay off the line
		repeat (6) @(posedge link_clk);
		`CHK(sda_oe, 1'b0);
		host_bus_master_inst.stop();
		go(1'b0, A, 1'b0);
		wb(8'hFE, 1'b0);
		go(1'b1, A, 1'b0);
		rb(8'h11, 1'b0);
		rb(8'h22, 1'b0);
		rb(8'h33, 1'b1);
		host_bus_master_inst.stop();
		$display("read test done");
	endtask : t_reads

	task automatic t_pointer();
		go(1'b0, A, 1'b0);
		wb(8'h10, 1'b0);
		host_bus_master_inst.stop();
		repeat (2) begin
			go(1'b1, A, 1'b0);
			rb(pat(8'h10), 1'b1);
			host_bus_master_inst.stop();
		end
		@(posedge clk);
		#1 deep_sleep_flag = 1'b1;
		go(1'b0, A, 1'b0);
		wb(8'h20, 1'b0);
		host_bus_master_inst.stop();
		@(posedge clk);
		#1 deep_sleep_flag = 1'b0;
		go(1'b1, A, 1'b0);
		rb(pat(8'h10), 1'b1);
		host_bus_master_inst.stop();
		$display("pointer test done");
	endtask : t_pointer

	// stall mid-transfer, then see whether the slave still listens
	task automatic t_stall(input logic en, input logic hi, input logic e);
		@(posedge clk);
		#1 timeout_enable = en;
		go(1'b0, A, 1'b0);
		host_bus_master_inst.hold(hi, hi ? 205000 : 35000);
		wb(8'h30, e);
		host_bus_master_inst.stop();
		@(posedge clk);
		#1 timeout_enable = 1'b0;
		$display("stall test done");
	endtask : t_stall

	initial begin
		sys_rst = 1'b1;
		spi_cs_n = 1'b1;
		protocol_address_strap = `STRAP_VDD;
		timeout_enable = 1'b0;
		deep_sleep_flag = 1'b0;
		n_errors = 0;
		checked = 0;
		for (int i = 0; i < 256; i++)
			mem[i] = pat(i);
		t_straps();
		t_block_write();
		t_reads();
		t_pointer();
		t_stall(1'b0, 1'b0, 1'b0);
		t_stall(1'b1, 1'b0, 1'b1);
		t_stall(1'b1, 1'b1, 1'b1);
		give_verdict();
	end

	// cut a hang short
	initial begin
		#2500000;
		n_errors++;
		$display("watchdog expired");
		give_verdict();
	end

endmodule : smbus_register_host_interface_tb

`default_nettype wire
